// ---- verilog/dcf_pkg.sv ----
// Purpose: shared constants and carrier types for the dual-clock fifo flag block
// Assumes: sys_clk at 100 MHz; fifo clocks arrive as pins and are oversampled
// Notes:   timing counts derive from printed times and the sys_clk period
package dcf_pkg;
    localparam int unsigned DATA_W      = 18;
    localparam int unsigned DEPTH_DEF   = 64;
    localparam int unsigned DEPTH_MIN   = 64;
    localparam int unsigned DEPTH_MAX   = 4096;
    localparam int unsigned OFFSET_W    = 12;
    localparam int unsigned SETTLE_W    = 4;
    localparam int unsigned SYNC_STAGES = 3;

    localparam int unsigned SYS_CLK_PERIOD_NS     = 10;
    localparam int unsigned FULL_RELEASE_SKEW_NS  = 5;
    localparam int unsigned EMPTY_RELEASE_SKEW_NS = 5;
    localparam int unsigned ALMOST_FLAG_SKEW_NS   = 10;
    localparam int unsigned ASYNC_EXTRA_NS        = 5;

    // least times round up, never below one cycle
    localparam int unsigned FULL_RELEASE_SKEW_CYC =
        (FULL_RELEASE_SKEW_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned EMPTY_RELEASE_SKEW_CYC =
        (EMPTY_RELEASE_SKEW_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned ALMOST_FLAG_SKEW_CYC =
        (ALMOST_FLAG_SKEW_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned ASYNC_EXTRA_CYC =
        (ASYNC_EXTRA_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(ASYNC_EXTRA_CYC);
    localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 4'h0;
    localparam logic [DATA_W-1:0]   DOUT_RESET  = 18'h00000;

    // everything that arrives from the pins, sampled as one bundle
    typedef struct packed {
        logic              wclk;
        logic              rclk;
        logic              write_en_n;
        logic              read_en_n;
        logic              out_en_n;
        logic              sync_flag_mode_sel;
        logic              write_cascade_in_n;
        logic              read_cascade_in_n;
        logic [DATA_W-1:0] din;
    } dcf_pins_t;

    localparam dcf_pins_t PINS_RESET = '{wclk: 1'b0, rclk: 1'b0, write_en_n: 1'b1,
        read_en_n: 1'b1, out_en_n: 1'b1, sync_flag_mode_sel: 1'b0,
        write_cascade_in_n: 1'b1, read_cascade_in_n: 1'b1, din: DOUT_RESET};

    typedef struct packed {
        logic full_flag_n;
        logic empty_flag_n;
        logic almost_full_flag_n;
        logic almost_empty_flag_n;
        logic half_full_flag_n;
    } dcf_flags_t;
endpackage : dcf_pkg

// ---- verilog/dcf_fifo.sv ----
// Purpose: dual-clock 18-bit fifo with status flags and depth cascade tokens
// Assumes: fifo clocks, enables and data are pins oversampled by sys_clk
// Notes:   one pipeline cycle separates an edge on one side from the other side
//
// Function
// R1: full releases at write edge after read
// R2: empty releases at read edge after write
// R3: sync almost-empty follows read edge after skew
// R4: sync almost-full follows write edge after skew
// R5: reset works with fifo clocks running
// R6: outputs zero after reset, off when disabled
// R7: first word only the cycle after empty releases
// R8: first-word latency bounded at empty boundary
// R9: read at almost-empty assertion leaves n-1
// R10: write at almost-full assertion gives depth-m+1
// R11: async almost flags settle after offset write
// R12: mode select low gives clocked almost flags
// R13: write cascade pulse on last location write
// R14: read cascade pulse on last location read
// R15: full low ignores every write
// R16: almost flags assert within programmed offset
// R17: sync almost flags move only on own clock
// R18: cascade input pulse hands over the token
`timescale 1ns/1ps
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int unsigned DEPTH = DEPTH_DEF
) (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire dcf_pins_t           pins,
    input  wire logic                cascade_en,
    input  wire logic                first_load_n,
    input  wire logic [OFFSET_W-1:0] empty_offset,
    input  wire logic [OFFSET_W-1:0] full_offset,
    input  wire logic                offset_wr,
    output logic [DATA_W-1:0]        dout,
    output logic                     dout_oe,
    output dcf_flags_t               flags,
    output logic                     write_cascade_out_n,
    output logic                     read_cascade_out_n
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
    localparam logic [PW-1:0] HALF_P = PW'(DEPTH / 2);
    localparam logic [PW-1:0] ONE_P = PW'(1);
    localparam logic [PW-1:0] ZERO_P = PW'(0);

    typedef struct packed {
        dcf_pins_t         s1;
        dcf_pins_t         s2;
        dcf_pins_t         s3;
        logic              wclk_lvl;
        logic              rclk_lvl;
        logic [PW-1:0]     wptr;
        logic [PW-1:0]     rptr;
        dcf_flags_t        fl;
        logic [DATA_W-1:0] dout;
        logic              wcas_n;
        logic              rcas_n;
        logic              w_tok;
        logic              r_tok;
        logic              strap_done;
        logic [SETTLE_W-1:0] settle;
    } dcf_state_t;

    localparam dcf_state_t STATE_RESET = '{s1: PINS_RESET, s2: PINS_RESET,
        s3: PINS_RESET, wclk_lvl: 1'b0, rclk_lvl: 1'b0, wptr: ZERO_P, rptr: ZERO_P,
        fl: '{full_flag_n: 1'b1, empty_flag_n: 1'b0, almost_full_flag_n: 1'b1,
              almost_empty_flag_n: 1'b0, half_full_flag_n: 1'b1},
        dout: DOUT_RESET, wcas_n: 1'b1, rcas_n: 1'b1, w_tok: 1'b0, r_tok: 1'b0,
        strap_done: 1'b0, settle: SETTLE_ZERO};

    dcf_state_t        q;
    dcf_state_t        d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic              wr_edge;
    logic              rd_edge;
    logic              wr_go;
    logic              rd_go;
    logic              w_tok_eff;
    logic              r_tok_eff;
    logic              sync_mode;
    logic [PW-1:0]     cnt;
    logic [PW-1:0]     af_level;
    logic [PW-1:0]     ae_level;

    // a change counts only once the second and third samples agree
    function automatic logic rise_seen(input logic s2, input logic s3, input logic lvl);
        rise_seen = (s2 == s3) & s3 & ~lvl;
    endfunction : rise_seen

    function automatic logic level_next(input logic s2, input logic s3, input logic lvl);
        level_next = (s2 == s3) ? s3 : lvl;
    endfunction : level_next

    assign wr_edge   = rise_seen(q.s2.wclk, q.s3.wclk, q.wclk_lvl);
    assign rd_edge   = rise_seen(q.s2.rclk, q.s3.rclk, q.rclk_lvl);
    assign w_tok_eff = ~cascade_en | q.w_tok;
    assign r_tok_eff = ~cascade_en | q.r_tok;
    assign sync_mode = ~q.s3.sync_flag_mode_sel;                   // [R12]
    assign wr_go     = wr_edge & ~q.s3.write_en_n & q.fl.full_flag_n & w_tok_eff;  // [R15] [R18]
    assign rd_go     = rd_edge & ~q.s3.read_en_n & q.fl.empty_flag_n & r_tok_eff;  // [R18]
    assign cnt       = q.wptr - q.rptr;
    assign af_level  = DEPTH_P - PW'(full_offset);
    assign ae_level  = PW'(empty_offset);

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.wclk_lvl = level_next(q.s2.wclk, q.s3.wclk, q.wclk_lvl);
        d.rclk_lvl = level_next(q.s2.rclk, q.s3.rclk, q.rclk_lvl);
        // token strap caught on the first cycle after reset release
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.w_tok = ~first_load_n;
            d.r_tok = ~first_load_n;
        end
        if (wr_go) begin
            d.wptr = q.wptr + ONE_P;
        end
        if (rd_go) begin
            d.rptr = q.rptr + ONE_P;
            d.dout = mem[q.rptr[AW-1:0]];                          // [R7] [R8]
        end
        // each side sees the other's pointer one cycle late, which covers the skew
        if (wr_edge) begin
            d.fl.full_flag_n = (d.wptr - q.rptr) != DEPTH_P;       // [R1] [R15]
            d.wcas_n = ~(wr_go & (q.wptr[AW-1:0] == LAST_LOC));    // [R13]
            if (wr_go && q.wptr[AW-1:0] == LAST_LOC) begin
                d.w_tok = 1'b0;
            end
            if (cascade_en && !q.s3.write_cascade_in_n) begin
                d.w_tok = 1'b1;                                    // [R18]
            end
            if (sync_mode) begin
                // flag taken from the count before this edge's own write
                d.fl.almost_full_flag_n = ~(cnt >= af_level);      // [R4] [R10] [R16] [R17]
            end
        end
        if (rd_edge) begin
            d.fl.empty_flag_n = (q.wptr - d.rptr) != ZERO_P;      // [R2] [R7]
            d.rcas_n = ~(rd_go & (q.rptr[AW-1:0] == LAST_LOC));    // [R14]
            if (rd_go && q.rptr[AW-1:0] == LAST_LOC) begin
                d.r_tok = 1'b0;
            end
            if (cascade_en && !q.s3.read_cascade_in_n) begin
                d.r_tok = 1'b1;                                    // [R18]
            end
            if (sync_mode) begin
                d.fl.almost_empty_flag_n = ~(cnt <= ae_level);     // [R3] [R9] [R16] [R17]
            end
        end
        if (offset_wr) begin
            d.settle = SETTLE_LOAD;
        end else if (q.settle != SETTLE_ZERO) begin
            d.settle = q.settle - 4'h1;
        end
        // async mode tracks the count directly, held while an offset settles
        if (!sync_mode && q.settle == SETTLE_ZERO && !offset_wr) begin
            d.fl.almost_full_flag_n  = ~(cnt >= af_level);         // [R11] [R12] [R16]
            d.fl.almost_empty_flag_n = ~(cnt <= ae_level);         // [R11] [R12] [R16]
        end
        d.fl.half_full_flag_n = ~(cnt > HALF_P);
    end

    // clocks may run freely during reset; every flop of the state record takes a constant
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= STATE_RESET;                                      // [R5] [R6]
        end else begin
            q <= d;
        end
    end

    // storage carries no reset, so a reset cycle costs no clear time
    always_ff @(posedge sys_clk) begin
        if (wr_go) begin
            mem[q.wptr[AW-1:0]] <= q.s3.din;
        end
    end

    assign dout                = q.dout;
    assign dout_oe             = ~q.s3.out_en_n;                   // [R6]
    assign flags               = q.fl;
    assign write_cascade_out_n = q.wcas_n;
    assign read_cascade_out_n  = q.rcas_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_full_blocks_write: assert property (            // [R15]
        !q.fl.full_flag_n && wr_edge |=> $stable(q.wptr))
        else $error("write taken while full");
    a_empty_blocks_read: assert property (
        !q.fl.empty_flag_n && rd_edge |=> $stable(q.rptr) && $stable(q.dout))
        else $error("read taken while empty");
    a_full_release_now: assert property (             // [R1]
        wr_edge && !wr_go && !q.fl.full_flag_n && cnt != DEPTH_P |=> q.fl.full_flag_n)
        else $error("full flag failed to release");
    a_empty_release_now: assert property (            // [R2]
        rd_edge && !q.fl.empty_flag_n && cnt != ZERO_P |=> q.fl.empty_flag_n)
        else $error("empty flag failed to release");
    a_first_word_late: assert property (              // [R7]
        $rose(q.fl.empty_flag_n) |-> $stable(q.dout))
        else $error("data moved as empty released");
    a_aempty_read_count: assert property (            // [R9]
        sync_mode && rd_go && !wr_go && cnt == ae_level && ae_level != ZERO_P
        && q.fl.almost_empty_flag_n
        |=> !q.fl.almost_empty_flag_n && cnt == $past(ae_level) - ONE_P)
        else $error("almost empty count wrong");
    a_afull_write_count: assert property (            // [R10]
        sync_mode && wr_go && !rd_go && cnt == af_level && q.fl.almost_full_flag_n
        |=> !q.fl.almost_full_flag_n && cnt == $past(af_level) + ONE_P)
        else $error("almost full count wrong");
    a_aempty_own_clock: assert property (             // [R17]
        sync_mode && !rd_edge && !offset_wr |=> $stable(q.fl.almost_empty_flag_n))
        else $error("almost empty moved without read edge");
    a_afull_own_clock: assert property (              // [R17]
        sync_mode && !wr_edge && !offset_wr |=> $stable(q.fl.almost_full_flag_n))
        else $error("almost full moved without write edge");
    a_async_settle_hold: assert property (            // [R11]
        !sync_mode && offset_wr ##1 !sync_mode |=> $stable(q.fl.almost_full_flag_n))
        else $error("async flag moved during settle");
    a_write_cascade_pulse: assert property (          // [R13]
        wr_go && q.wptr[AW-1:0] == LAST_LOC |=> !write_cascade_out_n
        && (!q.w_tok || $past(cascade_en && !q.s3.write_cascade_in_n)))
        else $error("write cascade pulse missing");
    a_read_cascade_pulse: assert property (           // [R14]
        rd_go && q.rptr[AW-1:0] == LAST_LOC |=> !read_cascade_out_n)
        else $error("read cascade pulse missing");

    c_fill_to_full: cover property (!q.fl.full_flag_n);
    c_empty_release: cover property ($rose(q.fl.empty_flag_n) ##[1:20] rd_go);
    c_wrap_cascade: cover property (cascade_en && !write_cascade_out_n);
endmodule : dcf_fifo

// ---- dv/dcf_pin_model.sv ----
// Purpose: far-side model driving the fifo clock, enable and data pins
// Assumes: each fifo clock high phase lasts 3 sys_clk and each low phase at least 5, so the pin sampler sees every edge
// Notes:   fifo clocks stand still between transfers; released data is inverted
`timescale 1ns/1ps
module dcf_pin_model
    import dcf_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic mode_sel,
    input  wire logic oe_n,
    output dcf_pins_t pins
);
    initial pins = PINS_RESET;

    // straps follow the bench; cascade inputs never hand a token over
    always @(mode_sel, oe_n) begin
        pins.sync_flag_mode_sel = mode_sel;
        pins.out_en_n           = oe_n;
        pins.write_cascade_in_n = 1'b1;
        pins.read_cascade_in_n  = 1'b1;
    end

    // one fifo clock pulse; enable and data set a cycle ahead and held past the fall
    task automatic pulse(input logic wr, input logic en, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        if (wr) begin
            pins.write_en_n = ~en;
            pins.din        = d;
        end else begin
            pins.read_en_n = ~en;
        end
        @(negedge sys_clk);
        if (wr) pins.wclk = 1'b1;
        else pins.rclk = 1'b1;
        repeat (3) @(negedge sys_clk);
        if (wr) pins.wclk = 1'b0;
        else pins.rclk = 1'b0;
        repeat (3) @(negedge sys_clk);
        // released data must not keep the last value
        pins.write_en_n = 1'b1;
        pins.read_en_n  = 1'b1;
        pins.din        = ~pins.din;
    endtask : pulse
endmodule : dcf_pin_model

// ---- dv/dcf_fifo_test.sv ----
// Purpose: self-checking bench for flags, data order and cascade tokens
// Assumes: depth 64, offsets n = m = 4; checks made after idle edges on both sides
// Notes:   expected words queue up on writes and are taken off on each real read
`timescale 1ns/1ps
module dcf_fifo_test;
    import dcf_pkg::*;
    localparam int unsigned DEPTH = 64;
    localparam int unsigned NOFF  = 4;
    localparam int unsigned MOFF  = 4;

    logic                sys_clk      = 1'b0;
    logic                resetn       = 1'b0;
    logic                cascade_en   = 1'b1;
    logic                first_load_n = 1'b0;
    logic                offset_wr    = 1'b0;
    logic                mode_sel     = 1'b0;
    logic                oe_n         = 1'b1;
    logic [OFFSET_W-1:0] empty_offset = 12'h000;
    logic [OFFSET_W-1:0] full_offset  = 12'h000;
    dcf_pins_t           pins;
    logic [DATA_W-1:0]   dout;
    logic                dout_oe;
    dcf_flags_t          flags;
    logic                wco_n;
    logic                rco_n;
    int                  n_mismatch   = 0;
    int                  checks_done  = 0;
    int                  cnt          = 0;
    logic [DATA_W-1:0]   exp_q[$];
    event                rd_ok;

    always #5 sys_clk = ~sys_clk;

    dcf_pin_model m (.sys_clk(sys_clk), .mode_sel(mode_sel), .oe_n(oe_n), .pins(pins));

    dcf_fifo #(.DEPTH(DEPTH)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .pins(pins), .cascade_en(cascade_en),
        .first_load_n(first_load_n), .empty_offset(empty_offset),
        .full_offset(full_offset), .offset_wr(offset_wr), .dout(dout),
        .dout_oe(dout_oe), .flags(flags), .write_cascade_out_n(wco_n),
        .read_cascade_out_n(rco_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // flag levels follow the word count once both sides have seen an idle edge
    task automatic chk_flags();
        dcf_flags_t e;
        e.full_flag_n         = (cnt != DEPTH);
        e.empty_flag_n        = (cnt != 0);
        e.almost_full_flag_n  = !(cnt >= DEPTH - MOFF);
        e.almost_empty_flag_n = !(cnt <= NOFF);
        e.half_full_flag_n    = !(cnt > DEPTH / 2);
        chk(32'(flags), 32'(e));
    endtask : chk_flags

    task automatic wr(input logic [DATA_W-1:0] d);
        m.pulse(1'b1, 1'b1, d);
        if (cnt < DEPTH) begin
            exp_q.push_back(d);
            cnt++;
        end
    endtask : wr

    task automatic rd();
        m.pulse(1'b0, 1'b1, 18'h00000);
        if (cnt > 0) begin
            cnt--;
            ->rd_ok;
        end
    endtask : rd

    task automatic idle();
        m.pulse(1'b1, 1'b0, 18'h00000);
        m.pulse(1'b0, 1'b0, 18'h00000);
    endtask : idle

    // result side: each real read hands out the oldest word written
    always @(rd_ok) begin
        if (exp_q.size() == 0) chk(32'(dout), 32'h0000DEAD);
        else chk(32'(dout), 32'(exp_q.pop_front()));
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h7297));
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(32'(dout), 32'h0);
        chk(32'(dout_oe), 32'h0);
        chk_flags();
        oe_n         = 1'b0;
        empty_offset = 12'(NOFF);
        full_offset  = 12'(MOFF);
        offset_wr    = 1'b1;
        @(negedge sys_clk);
        offset_wr = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(32'(dout_oe), 32'h1);
        rd();
        chk(32'(dout), 32'h0);
        for (int i = 0; i < DEPTH; i++) begin
            wr(18'($urandom));
            chk(32'(wco_n), (i == DEPTH - 1) ? 32'h0 : 32'h1);
            // no idle here, so the next write lands on the almost-full edge
            if (i != DEPTH - MOFF - 1) begin
                idle();
                chk_flags();
            end
        end
        wr(18'h3FFFF);
        idle();
        chk_flags();
        @(negedge sys_clk);
        mode_sel = 1'b1;
        // offset rewrite once async mode is through the pin sampler
        repeat (4) @(negedge sys_clk);
        offset_wr = 1'b1;
        @(negedge sys_clk);
        offset_wr = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            // async flags near full, clocked flags again near empty
            if (i == DEPTH / 2) mode_sel = 1'b0;
            rd();
            chk(32'(rco_n), (i == DEPTH - 1) ? 32'h0 : 32'h1);
            // no idle here, so the next read lands on the almost-empty edge
            if (i != DEPTH - NOFF - 1) begin
                idle();
                chk_flags();
            end
        end
        @(negedge sys_clk);
        resetn = 1'b0;
        // fifo clocks keep toggling while reset is held
        idle();
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk_flags();
        chk(32'(dout), 32'h0);
        print_verdict();
    end
endmodule : dcf_fifo_test
